// ===== in_filter.sv
`default_nettype none
// Two-flop synchroniser followed by a stability filter per bit
module in_filter #(
  parameter int WIDTH = 1,
  parameter int STABLE = 1
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // Raw and filtered levels
  input wire logic [WIDTH-1:0] in_i,
  output logic [WIDTH-1:0] out_o
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] out;
    logic [WIDTH-1:0][7:0] cnt;
  } filt_t;

  filt_t q_q;
  filt_t d_d;

  // Output follows only after STABLE cycles of a changed level
  always_comb begin
    d_d = q_q;
    d_d.s1 = in_i;
    d_d.s2 = q_q.s1;
    for (int i = 0; i < WIDTH; i++) begin
      if (q_q.s2[i] == q_q.out[i]) begin
        d_d.cnt[i] = 8'h00;
      end else if (q_q.cnt[i] == 8'(STABLE - 1)) begin
        d_d.out[i] = q_q.s2[i];
        d_d.cnt[i] = 8'h00;
      end else begin
        d_d.cnt[i] = q_q.cnt[i] + 8'h01;
      end
    end
  end

  // All inputs idle high after reset
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      q_q <= '0;
      q_q.s1 <= '1;
      q_q.s2 <= '1;
      q_q.out <= '1;
    end else begin
      q_q <= d_d;
    end
  end

  assign out_o = q_q.out;
endmodule
`default_nettype wire

// ===== pwr_far_side.sv
`default_nettype none
// Battery monitors, power-fail comparator, reset button and watch crystal
module pwr_far_side (
  // Commands from the bench
  input wire logic on_mains_i,
  input wire logic batt_dead_i,
  input wire logic batt_gone_i,
  input wire logic fail_i,
  input wire logic press_i,
  input wire logic cold_i,
  // Pins toward the controller
  output logic battery_ok_in_o,
  output logic external_power_sense_n_o,
  output logic battery_absent_n_o,
  output logic power_fail_n_o,
  output logic user_reset_n_o,
  output logic power_on_reset_n_o,
  output logic rtc_osc_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Comparator and switch levels, all active low except battery ok
  assign battery_ok_in_o = !(batt_dead_i || batt_gone_i);
  assign external_power_sense_n_o = !on_mains_i;
  assign battery_absent_n_o = !batt_gone_i;
  assign power_fail_n_o = !fail_i;
  assign user_reset_n_o = !press_i;
  assign power_on_reset_n_o = !cold_i;
  // Watch crystal runs free, also in standby
  initial rtc_osc_o = 1'b0;
  always #15259 rtc_osc_o = !rtc_osc_o;
endmodule
`default_nettype wire

// ===== pwr_pkg.sv
// What this block does
// - Any of three reset inputs makes system reset
// - System reset zeroes registers except refresh, clock
// - Core held reset until operating state returns
// - Power-on reset wins, forces reset, active low
// - Power-on reset sets cold flag, clears others
// - System reset lowers active, forces standby
// - System reset puts DRAM into self-refresh
// - Active high in operating, idle; low standby
// - Active low disables clocked peripherals
// - Halt write enters idle, CPU clock stops
// - Interrupt in idle resumes operating state
// - Standby write moves operating to standby
// - Interrupt in standby returns to operating
// - Low battery blocks leaving standby while external sense is low
// - Oscillator settle timeout before restart
// - Expansion clock only during I/O cycles unless free-running
// - Slow oscillator drives seconds counter except during system reset
// - Battery-ok deglitched, fall raises fast interrupt
// - Power fail deglitched, forces standby
// - Wake rising edge forces operating state
// - Self-refresh entered before oscillator stops
// - Wake needs power-fail off, external or battery
// - Forced standby waits for DRAM cycle end
`default_nettype none
package pwr_pkg;
  // Register byte addresses
  localparam logic [31:0] ADDR_HALT = 32'h8000_0800;
  localparam logic [31:0] ADDR_STANDBY = 32'h8000_0840;
  localparam logic [31:0] ADDR_STATUS = 32'h8000_0880;
  localparam logic [31:0] ADDR_CONTROL = 32'h8000_08c0;
  localparam logic [31:0] ADDR_REFRESH = 32'h8000_0900;
  localparam logic [31:0] ADDR_RTC = 32'h8000_0940;

  // Status register bit positions
  localparam int STAT_COLD = 0;
  localparam int STAT_BATTERY_OK_IN = 1;
  localparam int STAT_EXTPWR = 2;
  localparam int STAT_ABSENT = 3;
  localparam int STAT_PWRFAIL = 4;
  localparam int STAT_RUN = 5;
  localparam int STAT_CPUCLK = 6;

  // Control register bit positions
  localparam int CTRL_SR_EN = 0;
  localparam int CTRL_EXP_FREE = 1;

  // Positions in the plain synchronised input group
  localparam int FAST_POR = 0;
  localparam int FAST_URST = 1;
  localparam int FAST_EXT = 2;
  localparam int FAST_ABSENT = 3;
  localparam int FAST_WAKE = 4;
  localparam int FAST_TICK = 5;
  localparam int FAST_W = 6;

  // Positions in the deglitched input group
  localparam int SLOW_PF = 0;
  localparam int SLOW_BAT = 1;
  localparam int SLOW_W = 2;

  // Values after power-on reset
  localparam logic [7:0] REFRESH_RST = 8'h00;
  localparam logic [31:0] RTC_RST = 32'h0000_0000;

  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int OSC_SETTLE_NS = 1000;
  localparam int OSC_SETTLE_CYC =
    (OSC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] SETTLE_LAST = 8'(OSC_SETTLE_CYC - 1);
  localparam int DEGLITCH_NS = 100;
  localparam int DEGLITCH_CYC =
    (DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PLAIN_CYC = 1;
  // Slow oscillator edges per second, last prescaler value
  localparam logic [14:0] RTC_PRESCALE_LAST = 15'h7fff;

  // Power states
  typedef enum logic [2:0] {
    ST_STANDBY,
    ST_WAKE_WAIT,
    ST_OPERATE,
    ST_IDLE,
    ST_SR_ENTER
  } pwr_state_t;
endpackage
`default_nettype wire

// ===== pwr_state_ctrl.sv
// The implementer's own choice: the plain strobed port.
`default_nettype none
module pwr_state_ctrl (
  // Clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // Reset pins
  input wire logic power_on_reset_n_i,
  input wire logic power_fail_n_i,
  input wire logic user_reset_n_i,
  // Power management pins
  input wire logic battery_ok_in_i,
  input wire logic external_power_sense_n_i,
  input wire logic battery_absent_n_i,
  input wire logic wake_input_i,
  input wire logic rtc_osc_i,
  // System side
  input wire logic irq_i,
  input wire logic dram_busy_i,
  input wire logic io_cycle_i,
  // Register port
  input wire logic [31:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  output logic [31:0] rdata_o,
  // Control outputs
  output logic system_reset_n_o,
  output logic cpu_reset_n_o,
  output logic cpu_clock_en_o,
  output logic active_o,
  output logic periph_enable_o,
  output logic main_osc_en_o,
  output logic self_refresh_o,
  output logic expansion_clock_en_o,
  output logic fast_irq_o,
  output logic [7:0] refresh_period_o
);
  typedef struct packed {
    pwr_pkg::pwr_state_t state;
    logic sysres_n;
    logic cpu_rst_n;
    logic cpu_clk_en;
    logic run;
    logic osc_en;
    logic sr;
    logic expansion_clock_out_en;
    logic fiq;
    logic cold;
    logic sr_en;
    logic exp_free;
    logic [7:0] refresh;
    logic [31:0] rtc;
    logic [14:0] prescale;
    logic [7:0] timer;
    logic bat_prev;
    logic wake_prev;
    logic tick_prev;
    logic [31:0] rdata;
  } ctrl_t;

  ctrl_t q_q;
  ctrl_t d_d;
  logic [pwr_pkg::FAST_W-1:0] fast_raw;
  logic [pwr_pkg::FAST_W-1:0] fast_f;
  logic [pwr_pkg::SLOW_W-1:0] slow_raw;
  logic [pwr_pkg::SLOW_W-1:0] slow_f;
  logic por_ok;
  logic ur_ok;
  logic pf_ok;
  logic bat_f;
  logic ext_f;
  logic absent_f;
  logic wake_rise;
  logic tick_rise;
  logic warm_ok;
  logic wake_ok;
  logic [31:0] status;

  // Pins pass three flops before use
  assign fast_raw = {rtc_osc_i, wake_input_i, battery_absent_n_i,
                     external_power_sense_n_i, user_reset_n_i,
                     power_on_reset_n_i};
  assign slow_raw = {battery_ok_in_i, power_fail_n_i};

  in_filter #(
    .WIDTH(pwr_pkg::FAST_W),
    .STABLE(pwr_pkg::PLAIN_CYC)
  ) u_fast (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .in_i(fast_raw),
    .out_o(fast_f)
  );

  // Power fail and battery-ok are deglitched
  in_filter #(
    .WIDTH(pwr_pkg::SLOW_W),
    .STABLE(pwr_pkg::DEGLITCH_CYC)
  ) u_slow (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .in_i(slow_raw),
    .out_o(slow_f)
  );

  // Filtered levels and edges on the always-on clock
  assign por_ok = fast_f[pwr_pkg::FAST_POR];
  assign ur_ok = fast_f[pwr_pkg::FAST_URST];
  assign ext_f = fast_f[pwr_pkg::FAST_EXT];
  assign absent_f = fast_f[pwr_pkg::FAST_ABSENT];
  assign pf_ok = slow_f[pwr_pkg::SLOW_PF];
  assign bat_f = slow_f[pwr_pkg::SLOW_BAT];
  assign wake_rise = fast_f[pwr_pkg::FAST_WAKE] & ~q_q.wake_prev;
  assign tick_rise = fast_f[pwr_pkg::FAST_TICK] & ~q_q.tick_prev;
  assign warm_ok = pf_ok & ur_ok;
  assign wake_ok = pf_ok & (ext_f | bat_f);

  // Status word seen by software
  always_comb begin
    status = 32'h0000_0000;
    status[pwr_pkg::STAT_COLD] = q_q.cold;
    status[pwr_pkg::STAT_BATTERY_OK_IN] = bat_f;
    status[pwr_pkg::STAT_EXTPWR] = ext_f;
    status[pwr_pkg::STAT_ABSENT] = absent_f;
    status[pwr_pkg::STAT_PWRFAIL] = pf_ok;
    status[pwr_pkg::STAT_RUN] = q_q.run;
    status[pwr_pkg::STAT_CPUCLK] = q_q.cpu_clk_en;
  end

  // Next state of the whole controller
  always_comb begin
    d_d = q_q;
    d_d.fiq = 1'b0;
    d_d.rdata = 32'h0000_0000;
    d_d.sysres_n = 1'b1;
    d_d.bat_prev = bat_f;
    d_d.wake_prev = fast_f[pwr_pkg::FAST_WAKE];
    d_d.tick_prev = fast_f[pwr_pkg::FAST_TICK];
    // Master clock leaves the chip only in I/O cycles unless free
    d_d.expansion_clock_out_en = q_q.run & (q_q.exp_free | io_cycle_i);
    // Seconds counter keeps going in every state except during system reset
    if (tick_rise) begin
      if (q_q.prescale == pwr_pkg::RTC_PRESCALE_LAST) begin
        d_d.prescale = '0;
        d_d.rtc = q_q.rtc + 32'h0000_0001;
      end else begin
        d_d.prescale = q_q.prescale + 15'h0001;
      end
    end
    // Battery falling edge raises a fast interrupt
    if (q_q.bat_prev & ~bat_f) begin
      d_d.fiq = 1'b1;
    end
    // Register reads, answered one cycle later
    if (re_i) begin
      if (addr_i == pwr_pkg::ADDR_STATUS) begin
        d_d.rdata = status;
      end else if (addr_i == pwr_pkg::ADDR_CONTROL) begin
        d_d.rdata[pwr_pkg::CTRL_SR_EN] = q_q.sr_en;
        d_d.rdata[pwr_pkg::CTRL_EXP_FREE] = q_q.exp_free;
      end else if (addr_i == pwr_pkg::ADDR_REFRESH) begin
        d_d.rdata[7:0] = q_q.refresh;
      end else if (addr_i == pwr_pkg::ADDR_RTC) begin
        d_d.rdata = q_q.rtc;
      end
    end
    // Register writes
    if (we_i) begin
      if (addr_i == pwr_pkg::ADDR_STATUS) begin
        if (wdata_i[pwr_pkg::STAT_COLD]) begin
          d_d.cold = 1'b0;
        end
      end else if (addr_i == pwr_pkg::ADDR_CONTROL) begin
        d_d.sr_en = wdata_i[pwr_pkg::CTRL_SR_EN];
        d_d.exp_free = wdata_i[pwr_pkg::CTRL_EXP_FREE];
      end else if (addr_i == pwr_pkg::ADDR_REFRESH) begin
        d_d.refresh = wdata_i[7:0];
      end else if (addr_i == pwr_pkg::ADDR_RTC) begin
        d_d.rtc = wdata_i;
        d_d.prescale = '0;
      end
    end
    // Power state sequence
    case (q_q.state)
      pwr_pkg::ST_OPERATE: begin
        if (we_i && addr_i == pwr_pkg::ADDR_HALT) begin
          d_d.state = pwr_pkg::ST_IDLE;
          d_d.cpu_clk_en = 1'b0;
        end else if (we_i && addr_i == pwr_pkg::ADDR_STANDBY) begin
          d_d.state = pwr_pkg::ST_SR_ENTER;
          d_d.cpu_clk_en = 1'b0;
        end
      end
      pwr_pkg::ST_IDLE: begin
        if (irq_i) begin
          d_d.state = pwr_pkg::ST_OPERATE;
          d_d.cpu_clk_en = 1'b1;
        end
      end
      pwr_pkg::ST_SR_ENTER: begin
        // Let the memory cycle finish, then self-refresh first
        if (!dram_busy_i) begin
          d_d.sr = q_q.sr_en;
          d_d.run = 1'b0;
          d_d.state = pwr_pkg::ST_STANDBY;
        end
      end
      pwr_pkg::ST_STANDBY: begin
        // Oscillator stops one cycle after self-refresh begins
        d_d.osc_en = 1'b0;
        d_d.run = 1'b0;
        if ((wake_rise || irq_i) && wake_ok) begin
          d_d.state = pwr_pkg::ST_WAKE_WAIT;
          d_d.osc_en = 1'b1;
          d_d.timer = 8'h00;
        end
      end
      pwr_pkg::ST_WAKE_WAIT: begin
        // Restart only after the main oscillator has settled
        if (q_q.timer == pwr_pkg::SETTLE_LAST) begin
          d_d.state = pwr_pkg::ST_OPERATE;
          d_d.run = 1'b1;
          d_d.cpu_rst_n = 1'b1;
          d_d.cpu_clk_en = 1'b1;
          d_d.sr = 1'b0;
        end else begin
          d_d.timer = q_q.timer + 8'h01;
        end
      end
      default: begin
        d_d.state = pwr_pkg::ST_STANDBY;
      end
    endcase
    // Warm reset waits for a DRAM cycle to end, then holds
    if (!warm_ok && (!q_q.sysres_n || !dram_busy_i)) begin
      d_d = '0;
      d_d.state = pwr_pkg::ST_STANDBY;
      d_d.sr = 1'b1;
      d_d.refresh = q_q.refresh;
      d_d.rtc = d_d.rtc | q_q.rtc;
      d_d.prescale = q_q.prescale;
      d_d.bat_prev = bat_f;
      d_d.wake_prev = fast_f[pwr_pkg::FAST_WAKE];
      d_d.tick_prev = fast_f[pwr_pkg::FAST_TICK];
    end else if (!warm_ok) begin
      d_d.sysres_n = q_q.sysres_n;
    end
    // Power-on reset overrides everything at once
    if (!por_ok) begin
      d_d = '0;
      d_d.state = pwr_pkg::ST_STANDBY;
      d_d.sr = 1'b1;
      d_d.cold = 1'b1;
      d_d.refresh = pwr_pkg::REFRESH_RST;
      d_d.rtc = pwr_pkg::RTC_RST;
      d_d.bat_prev = bat_f;
      d_d.wake_prev = fast_f[pwr_pkg::FAST_WAKE];
      d_d.tick_prev = fast_f[pwr_pkg::FAST_TICK];
    end
  end

  // Block reset leaves a cold standby
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      q_q <= '0;
      q_q.state <= pwr_pkg::ST_STANDBY;
      q_q.sr <= 1'b1;
      q_q.cold <= 1'b1;
      q_q.bat_prev <= 1'b1;
      q_q.wake_prev <= 1'b1;
      q_q.tick_prev <= 1'b1;
    end else begin
      q_q <= d_d;
    end
  end

  // Outputs straight from the state flops
  assign rdata_o = q_q.rdata;
  assign system_reset_n_o = q_q.sysres_n;
  assign cpu_reset_n_o = q_q.cpu_rst_n;
  assign cpu_clock_en_o = q_q.cpu_clk_en;
  assign active_o = q_q.run;
  assign periph_enable_o = q_q.run;
  assign main_osc_en_o = q_q.osc_en;
  assign self_refresh_o = q_q.sr;
  assign expansion_clock_en_o = q_q.expansion_clock_out_en;
  assign fast_irq_o = q_q.fiq;
  assign refresh_period_o = q_q.refresh;

  // Checks
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!resetn_i);

  a_por_reset: assert property (
    !por_ok |=> !system_reset_n_o && !active_o && q_q.cold
  ) else $error("power-on reset not applied");

  a_warm_reset: assert property (
    por_ok && !warm_ok && !dram_busy_i
      |=> !system_reset_n_o && !cpu_reset_n_o
  ) else $error("warm reset not applied");

  a_reset_waits: assert property (
    por_ok && q_q.sysres_n && dram_busy_i |=> system_reset_n_o
  ) else $error("reset cut a memory cycle");

  a_reset_standby: assert property (
    !system_reset_n_o |-> !active_o && self_refresh_o
      && q_q.state == pwr_pkg::ST_STANDBY
  ) else $error("reset state not standby");

  a_run_level: assert property (
    active_o == (q_q.state inside {pwr_pkg::ST_OPERATE,
      pwr_pkg::ST_IDLE, pwr_pkg::ST_SR_ENTER}) // Runs until memory idle
  ) else $error("active output wrong for state");

  a_halt_idle: assert property (
    por_ok && warm_ok && q_q.state == pwr_pkg::ST_OPERATE
      && we_i && addr_i == pwr_pkg::ADDR_HALT
      |=> q_q.state == pwr_pkg::ST_IDLE && !cpu_clock_en_o
        && main_osc_en_o
  ) else $error("halt did not enter idle");

  a_idle_resume: assert property (
    por_ok && warm_ok && q_q.state == pwr_pkg::ST_IDLE && irq_i
      |=> q_q.state == pwr_pkg::ST_OPERATE && cpu_clock_en_o
  ) else $error("interrupt did not leave idle");

  a_no_weak_wake: assert property (
    q_q.state == pwr_pkg::ST_STANDBY && !wake_ok
      |=> q_q.state == pwr_pkg::ST_STANDBY
  ) else $error("left standby on weak power");

  a_settle_wait: assert property (
    $rose(active_o) && system_reset_n_o
      |-> $past(q_q.state) == pwr_pkg::ST_WAKE_WAIT
        && $past(q_q.timer) == pwr_pkg::SETTLE_LAST
  ) else $error("restart before oscillator settled");

  a_sr_first: assert property (
    $fell(main_osc_en_o) && q_q.sr_en |-> self_refresh_o
  ) else $error("oscillator stopped before self-refresh");

  a_battery_ok_in_fiq: assert property (
    q_q.bat_prev && !bat_f |=> fast_irq_o
  ) else $error("battery fall gave no fast interrupt");

  c_idle_trip: cover property (
    q_q.state == pwr_pkg::ST_IDLE ##1 q_q.state == pwr_pkg::ST_OPERATE
  );
  c_standby_entry: cover property (
    q_q.state == pwr_pkg::ST_SR_ENTER ##1 q_q.state == pwr_pkg::ST_STANDBY
  );
  c_wake_up: cover property (
    wake_rise && q_q.state == pwr_pkg::ST_STANDBY ##1
      q_q.state == pwr_pkg::ST_WAKE_WAIT
  );
endmodule
`default_nettype wire

// ===== testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  // Bench drive
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic irq = 1'b0, busy = 1'b0, io_cyc = 1'b0, wake = 1'b0;
  logic we = 1'b0, re = 1'b0;
  logic [31:0] addr = 32'h0000_0000, wdata = 32'h0000_0000;
  logic mains = 1'b0, dead = 1'b0, gone = 1'b0;
  logic fail = 1'b0, press = 1'b0, cold = 1'b0;
  // Pins and outputs
  wire logic bat_ok, ext_n, absent_n, pf_n, urst_n, por_n, rtc_osc;
  wire logic sys_rst_n, cpu_rst_n, cpu_clk_en, active, periph_en;
  wire logic osc_en, self_ref, exp_en, fiq;
  wire logic [31:0] rdata;
  wire logic [7:0] refresh;
  // Scoreboard state
  logic [31:0] exp_q[$];
  logic rd_pend = 1'b0;
  logic [31:0] seed = 32'h0000_ba8c;
  int n_mismatch = 0;
  int n_checks = 0;
  int cycles = 0;

  always #5 clock = !clock;

  pwr_far_side i_pwr_far_side (
    .on_mains_i(mains), .batt_dead_i(dead), .batt_gone_i(gone),
    .fail_i(fail), .press_i(press), .cold_i(cold),
    .battery_ok_in_o(bat_ok), .external_power_sense_n_o(ext_n),
    .battery_absent_n_o(absent_n), .power_fail_n_o(pf_n),
    .user_reset_n_o(urst_n), .power_on_reset_n_o(por_n),
    .rtc_osc_o(rtc_osc)
  );

  pwr_state_ctrl i_pwr_state_ctrl (
    .clock_i(clock), .resetn_i(rst_n),
    .power_on_reset_n_i(por_n), .power_fail_n_i(pf_n),
    .user_reset_n_i(urst_n), .battery_ok_in_i(bat_ok),
    .external_power_sense_n_i(ext_n), .battery_absent_n_i(absent_n),
    .wake_input_i(wake), .rtc_osc_i(rtc_osc), .irq_i(irq),
    .dram_busy_i(busy), .io_cycle_i(io_cyc), .addr_i(addr),
    .wdata_i(wdata), .we_i(we), .re_i(re), .rdata_o(rdata),
    .system_reset_n_o(sys_rst_n), .cpu_reset_n_o(cpu_rst_n),
    .cpu_clock_en_o(cpu_clk_en), .active_o(active),
    .periph_enable_o(periph_en), .main_osc_en_o(osc_en),
    .self_refresh_o(self_ref), .expansion_clock_en_o(exp_en),
    .fast_irq_o(fiq), .refresh_period_o(refresh)
  );

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic logic pick(input int w);
    case (w)
      0: return active;
      1: return sys_rst_n;
      2: return fiq;
      default: return cpu_clk_en;
    endcase
  endfunction

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic fail_msg(input string m);
    n_mismatch++;
    $display("wrong value at %0t: %s", $time, m);
  endtask

  task automatic check_bit(input logic got, input logic want, string m);
    n_checks++;
    if (got !== want) fail_msg(m);
  endtask

  task automatic compare_word(input logic [31:0] got, want);
    n_checks++;
    if (got !== want) fail_msg($sformatf("read %h want %h", got, want));
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // Bounded wait on one output, then compare
  task automatic wait_for(input int w, logic want, int max, string m);
    int i;
    i = 0;
    while (pick(w) !== want && i < max) begin
      tick(1);
      i++;
    end
    check_bit(pick(w), want, m);
  endtask

  // One-cycle register write
  task automatic bus_wr(input logic [31:0] a, d);
    @(posedge clock);
    we <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    we <= 1'b0;
  endtask

  // One-cycle register read, result noted for the monitor
  task automatic bus_rd(input logic [31:0] a, want);
    exp_q.push_back(want);
    @(posedge clock);
    re <= 1'b1;
    addr <= a;
    @(posedge clock);
    re <= 1'b0;
  endtask

  // Wake pin edge, oscillator settle must pass first
  task automatic wake_up();
    @(posedge clock);
    wake <= 1'b1;
    tick(50);
    check_bit(active, 1'b0, "woke before settle");
    wait_for(0, 1'b1, 80, "wake pin ignored");
    @(posedge clock);
    wake <= 1'b0;
  endtask

  // Read data stand one cycle after the strobe
  always @(posedge clock) begin
    rd_pend <= re;
    if (rd_pend && exp_q.size() > 0) compare_word(rdata, exp_q.pop_front());
  end

  // Hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fail_msg("run too long");
      print_verdict();
    end
  end

  initial begin
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    tick(2);
    check_bit(sys_rst_n, 1'b1, "reset held");
    check_bit(active, 1'b0, "active after reset");
    check_bit(self_ref, 1'b1, "no self refresh");
    check_bit(cpu_rst_n, 1'b0, "core not in reset");
    tick(12);
    bus_rd(pwr_pkg::ADDR_STATUS, 32'h0000_001f);
    $display("test reset done");
    wake_up();
    check_bit(cpu_rst_n, 1'b1, "core still reset");
    check_bit(periph_en, 1'b1, "periph off");
    check_bit(self_ref, 1'b0, "self refresh on");
    bus_rd(pwr_pkg::ADDR_STATUS, 32'h0000_007f);
    for (int k = 0; k < 4; k++) begin
      seed = xorshift(seed);
      bus_wr(pwr_pkg::ADDR_REFRESH, seed);
      bus_rd(pwr_pkg::ADDR_REFRESH, {24'h00_0000, seed[7:0]});
    end
    bus_rd(32'h8000_0a00, 32'h0000_0000);
    bus_rd(pwr_pkg::ADDR_HALT, 32'h0000_0000);
    $display("test registers done");
    bus_wr(pwr_pkg::ADDR_HALT, seed);
    tick(1);
    check_bit(cpu_clk_en, 1'b0, "cpu clock runs");
    check_bit(active, 1'b1, "idle not active");
    @(posedge clock);
    irq <= 1'b1;
    @(posedge clock);
    irq <= 1'b0;
    wait_for(3, 1'b1, 3, "idle not left");
    @(posedge clock);
    fail <= 1'b1;
    repeat (3) @(posedge clock);
    fail <= 1'b0;
    tick(20);
    check_bit(active, 1'b1, "glitch taken");
    $display("test idle done");
    bus_wr(pwr_pkg::ADDR_CONTROL, 32'h0000_0001);
    @(posedge clock);
    busy <= 1'b1;
    bus_wr(pwr_pkg::ADDR_STANDBY, seed);
    tick(5);
    check_bit(active, 1'b1, "left during dram cycle");
    @(posedge clock);
    busy <= 1'b0;
    wait_for(0, 1'b0, 3, "standby refused");
    check_bit(self_ref, 1'b1, "no self refresh");
    check_bit(osc_en, 1'b1, "osc stopped early");
    check_bit(periph_en, 1'b0, "periph on");
    tick(1);
    check_bit(osc_en, 1'b0, "osc still on");
    $display("test standby done");
    @(posedge clock);
    dead <= 1'b1;
    mains <= 1'b1;
    wait_for(2, 1'b1, 20, "no fast interrupt");
    tick(1);
    check_bit(fiq, 1'b0, "fast interrupt held");
    @(posedge clock);
    wake <= 1'b1;
    tick(150);
    check_bit(active, 1'b0, "woke on low battery");
    @(posedge clock);
    wake <= 1'b0;
    mains <= 1'b0;
    irq <= 1'b1;
    wait_for(0, 1'b1, 130, "interrupt wake refused");
    @(posedge clock);
    irq <= 1'b0;
    dead <= 1'b0;
    io_cyc <= 1'b1;
    tick(2);
    check_bit(exp_en, 1'b1, "no expansion clock");
    @(posedge clock);
    io_cyc <= 1'b0;
    tick(2);
    check_bit(exp_en, 1'b0, "expansion clock on");
    bus_wr(pwr_pkg::ADDR_CONTROL, 32'h0000_0003);
    tick(2);
    check_bit(exp_en, 1'b1, "expansion clock not free");
    $display("test battery done");
    for (int k = 0; k < 2; k++) begin
      if (k == 1) wake_up();
      seed = xorshift(seed);
      bus_wr(pwr_pkg::ADDR_REFRESH, seed);
      bus_wr(pwr_pkg::ADDR_RTC, seed);
      @(posedge clock);
      press <= (k == 0);
      fail <= (k == 1);
      busy <= 1'b1;
      tick(20);
      check_bit(sys_rst_n, 1'b1, "reset cut dram cycle");
      @(posedge clock);
      busy <= 1'b0;
      wait_for(1, 1'b0, 20, "no system reset");
      check_bit(active, 1'b0, "active in reset");
      check_bit(cpu_rst_n, 1'b0, "core not reset");
      compare_word({24'h00_0000, refresh}, {24'h00_0000, seed[7:0]});
      @(posedge clock);
      press <= 1'b0;
      fail <= 1'b0;
      wait_for(1, 1'b1, 20, "reset stuck");
      bus_rd(pwr_pkg::ADDR_REFRESH, {24'h00_0000, seed[7:0]});
      bus_rd(pwr_pkg::ADDR_RTC, seed);
      bus_rd(pwr_pkg::ADDR_CONTROL, 32'h0000_0000);
      bus_rd(pwr_pkg::ADDR_STATUS, 32'h0000_001e);
    end
    $display("test warm reset done");
    @(posedge clock);
    cold <= 1'b1;
    wait_for(1, 1'b0, 10, "no cold reset");
    @(posedge clock);
    cold <= 1'b0;
    wait_for(1, 1'b1, 10, "cold reset stuck");
    bus_rd(pwr_pkg::ADDR_REFRESH, 32'h0000_0000);
    bus_rd(pwr_pkg::ADDR_RTC, 32'h0000_0000);
    bus_rd(pwr_pkg::ADDR_STATUS, 32'h0000_001f);
    wake_up();
    $display("test cold reset done");
    tick(3);
    print_verdict();
  end
endmodule
`default_nettype wire
